//--- src/asf_alu_status_flags.sv
// ALU with its status flag register (negative, overflow, zero, digit carry, carry).
`timescale 1ns/1ns
`default_nettype none
`include "asf_cfg.svh"
module asf_alu_status_flags
    import asf_pkg::*;
(
    input  wire logic     mclk,                        // Core clock, 125 MHz.
    input  wire logic     reset,                       // Synchronous reset, active high.
    input  wire asf_req_s req,                         // Operation and flag write request.
    input  wire logic     extended_instruction_enable, // Extended set configuration bit.
    output logic [7:0]    result,                      // Registered ALU result.
    output logic [7:0]    alu_flags,                   // Flag register read value.
    output logic          indexed_offset_mode_en       // Indexed literal offset available.
);

    // ==========================================================
    // State and working signals
    asf_state_s  state_r;
    asf_state_s  state_nxt;

    logic        is_add;
    logic        is_sub;
    logic        is_clr;
    logic        arith;

    logic        carry_in;
    logic [7:0]  b_eff;
    logic [8:0]  sum9;
    logic [4:0]  sum5;

    logic [7:0]  and_res;
    logic [7:0]  ior_res;
    logic [7:0]  xor_res;
    logic [7:0]  pass_res;
    logic [7:0]  res;

    logic        neg_calc;
    logic        ovf_calc;
    logic        zero_calc;
    logic        dc_calc;
    logic        c_calc;
    logic [4:0]  calc;

    logic [4:0]  wr_bits;
    logic [4:0]  flag_nxt;
    logic        clr_flags;

    // ==========================================================
    // Operation decode
    assign is_add = (req.op == ASF_OP_ADD);
    assign is_sub = (req.op == ASF_OP_SUB);
    assign is_clr = (req.op == ASF_OP_CLR);

    // Only the adder operations can report a signed overflow.
    assign arith  = is_add | is_sub;

    // ==========================================================
    // Adder
    // b inverted for subtract
    assign b_eff    = is_sub ? ~req.b : req.b;

    // A plain subtract adds one to finish the two's complement of b.
    // With carry in, the stored carry takes the place of that one.
    assign carry_in = is_sub ? (req.use_carry ? state_r.flags[`ASF_C_BIT] : 1'b1)
                             : (req.use_carry & state_r.flags[`ASF_C_BIT]);

    assign sum9     = {1'b0, req.a} + {1'b0, b_eff} + {8'h00, carry_in};
    assign sum5     = {1'b0, req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};

    // ==========================================================
    // Logic unit
    assign and_res  = req.a & req.b;
    assign ior_res  = req.a | req.b;
    assign xor_res  = req.a ^ req.b;
    assign pass_res = req.a;

    always_comb begin
        unique case (req.op)
            ASF_OP_ADD: begin
                res = sum9[7:0];
            end
            ASF_OP_SUB: begin
                res = sum9[7:0];
            end
            ASF_OP_AND: begin
                res = and_res;
            end
            ASF_OP_IOR: begin
                res = ior_res;
            end
            ASF_OP_XOR: begin
                res = xor_res;
            end
            ASF_OP_PASS: begin
                res = pass_res;
            end
            ASF_OP_NONE: begin
                res = 8'h00;
            end
            ASF_OP_CLR: begin
                res = 8'h00;
            end
            default: begin
                // Unused operation codes give a zero result.
                res = 8'h00;
            end
        endcase
    end

    // ==========================================================
    // Flag calculation
    // sign to negative
    assign neg_calc  = res[7];

    assign ovf_calc  = arith & (req.a[7] == b_eff[7]) & (res[7] != req.a[7]);

    assign zero_calc = (res == 8'h00);

    assign dc_calc   = sum5[4];

    assign c_calc    = sum9[8];

    // Packed in register order: negative, overflow, zero, digit carry, carry.
    assign calc      = {neg_calc, ovf_calc, zero_calc, dc_calc, c_calc};

    // ==========================================================
    // Flag write merge
    assign wr_bits   = req.wr_data[4:0];

    assign clr_flags = req.valid & req.wr_flags & is_clr;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
            assign flag_nxt[gi] = (req.valid && req.upd_mask[gi]) ? calc[gi] :
                                  (req.valid && req.wr_flags)     ? wr_bits[gi] :
                                                                    state_r.flags[gi];
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb begin
        state_nxt = state_r;
        if (req.valid) begin
            state_nxt.result = res;
        end
        state_nxt.flags = flag_nxt;
        if (clr_flags) begin
            state_nxt.flags[`ASF_Z_BIT] = 1'b1;
        end
    end

    // ==========================================================
    // State register
    // flags not forced by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r.result <= 8'h00;
        end else begin
            state_r.result <= state_nxt.result;
        end
        state_r.flags <= state_nxt.flags;
    end

    // ==========================================================
    // Read back
    // upper bits zero
    assign alu_flags = {3'b000, state_r.flags};

    assign result    = state_r.result;

    assign indexed_offset_mode_en = extended_instruction_enable;

endmodule
`default_nettype wire

//--- src/asf_cfg.svh
// Constants for the ALU status flag register: field positions, masks and initial value.
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH
`define ASF_N_BIT      3'd4
`define ASF_OV_BIT     3'd3
`define ASF_Z_BIT      3'd2
`define ASF_DC_BIT     3'd1
`define ASF_C_BIT      3'd0
`define ASF_FLAG_MASK  8'h1f
`define ASF_UNIMP_MASK 8'he0
`define ASF_FLAG_INIT  5'h00
`endif

//--- src/asf_pkg.sv
// Types for the ALU status flag register.
`include "asf_cfg.svh"
package asf_pkg;
    typedef enum logic [3:0] {
        ASF_OP_NONE = 4'h0,
        ASF_OP_ADD  = 4'h1,
        ASF_OP_SUB  = 4'h2,
        ASF_OP_AND  = 4'h3,
        ASF_OP_IOR  = 4'h4,
        ASF_OP_XOR  = 4'h5,
        ASF_OP_PASS = 4'h6,
        ASF_OP_CLR  = 4'h7
    } asf_op_e;

    typedef struct packed {
        logic       valid;
        asf_op_e    op;
        logic       use_carry;
        logic [7:0] a;
        logic [7:0] b;
        logic [4:0] upd_mask;
        logic       wr_flags;
        logic [7:0] wr_data;
    } asf_req_s;

    typedef struct packed {
        logic [7:0] result;
        logic [4:0] flags;
    } asf_state_s;
endpackage

//--- verification/asf_core_model.sv
// Core-side model that turns a command into a request.
`timescale 1ns/1ns
`default_nettype none
module asf_core_model
    import asf_pkg::*;
(
    input  wire logic [1:0]  kind, // 0 idle, 1 add or sub, 2 move, 3 clear.
    input  wire logic [16:0] x,    // Op select and operands.
    output var  asf_req_s    req   // Request.
);
    always_comb begin
        req = '0;
        {req.valid, req.wr_flags} = {kind != 2'h0, kind[1]};
        req.op = kind[1] ? (kind[0] ? ASF_OP_CLR : ASF_OP_PASS) : (x[16] ? ASF_OP_SUB : ASF_OP_ADD);
        {req.a, req.b, req.wr_data} = {x[15:0], x[7:0]};
        req.upd_mask = kind == 2'h1 ? 5'h1f : {2'h0, kind == 2'h3, 2'h0};
    end
endmodule
`default_nettype wire

//--- verification/asf_flags_properties.sv
// Port-level assertions for the flag block.
`timescale 1ns/1ns
`default_nettype none
module asf_flags_properties
    import asf_pkg::*;
(
    input wire logic       mclk,                        // Clock.
    input wire logic       reset,                       // Reset.
    input wire asf_req_s   req,                         // Request.
    input wire logic       extended_instruction_enable, // Mode bit.
    input wire logic [7:0] result,                      // Result.
    input wire logic [7:0] alu_flags,                   // Flags.
    input wire logic       indexed_offset_mode_en       // Mode out.
);
    logic [4:0] wr_low_r;
    logic       no_borrow_r;
    logic       add_carry_r;
    always_ff @(posedge mclk) begin
        wr_low_r    <= req.wr_data[4:0];
        no_borrow_r <= (req.a >= req.b);
        add_carry_r <= ({1'b0, req.a} + {1'b0, req.b}) > 9'h0ff;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_upd(int i);
        req.valid && req.upd_mask[i] && !req.wr_flags;
    endsequence
    a_upper_zero: assert property (alu_flags[7:5] == 3'h0) else $error("upper");
    a_neg_flag: assert property (s_upd(4) |=> alu_flags[4] == result[7]) else $error("neg");
    a_zero_flag: assert property (s_upd(2) |=> alu_flags[2] == (result == 8'h00))
        else $error("zero");
    a_flag_hold: assert property (!req.valid |=> $stable(alu_flags)) else $error("hold");
    a_move_write: assert property (req.valid && req.wr_flags && req.upd_mask == 5'h00
        |=> alu_flags[4:0] == wr_low_r) else $error("write");
    a_clear_zero: assert property (req.valid && req.wr_flags && req.op == ASF_OP_CLR
        |=> alu_flags[2]) else $error("clear");
    a_sub_borrow: assert property (s_upd(0) && req.op == ASF_OP_SUB && !req.use_carry
        |=> alu_flags[0] == no_borrow_r) else $error("borrow");
    a_add_carry: assert property (s_upd(0) && req.op == ASF_OP_ADD && !req.use_carry
        |=> alu_flags[0] == add_carry_r) else $error("carry");
    a_mode_copy: assert property (indexed_offset_mode_en == extended_instruction_enable)
        else $error("mode");
endmodule
bind asf_alu_status_flags asf_flags_properties u_props (.mclk(mclk), .reset(reset),
    .req(req), .extended_instruction_enable(extended_instruction_enable), .result(result),
    .alu_flags(alu_flags), .indexed_offset_mode_en(indexed_offset_mode_en));
`default_nettype wire

//--- verification/tb_alu_status_flags.sv
// Random bench for the flag block.
`timescale 1ns/1ns
`default_nettype none
module tb_alu_status_flags;
    logic mclk = 1'b0, reset = 1'b1, ext = 1'b0, mode;
    logic [1:0] kind = 2'h0;
    logic [16:0] x = 17'h0;
    logic [31:0] lf = 32'h22;
    logic [7:0] res, fl;
    logic [4:0] ef = 5'h0;
    int n_fail = 0, checks = 0, i, a, b, sm;
    asf_pkg::asf_req_s req;
    always #4 mclk = ~mclk;
    asf_core_model core (.kind(kind), .x(x), .req(req));
    asf_alu_status_flags DUT (.mclk(mclk), .reset(reset), .req(req), .result(res),
        .extended_instruction_enable(ext), .alu_flags(fl), .indexed_offset_mode_en(mode));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic step(input logic [1:0] k, input logic [16:0] v);
        if (k == 2'h3) v[7:0] = {3'h0, ef & 5'h1b};
        @(posedge mclk);
        {reset, kind, x, ext} <= {1'b0, k, v, v[16]};
        @(posedge mclk);
        #1;
        a = v[15:8];
        b = v[16] ? 255 - v[7:0] : v[7:0];
        sm = a + b + v[16];
        if (k == 2'h1) ef = {sm[7], a[7] == b[7] && sm[7] != a[7], sm[7:0] == 0,
            a % 16 + b % 16 + v[16] > 15, sm[8]};
        if (k == 2'h2) ef = v[4:0];
        if (k == 2'h3) ef[2] = 1'b1;
        checks++;
        if ((k == 2'h1 && res !== sm[7:0]) || (k == 2'h2 && res !== v[15:8])
            || (k == 2'h3 && res !== 8'h00) || {fl, mode} !== {3'h0, ef, ext}) begin
            n_fail++;
            $display("[FAIL] %0t got %h %h", $time, res, fl);
        end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        step(2'h2, 17'h000ea);
        step(2'h1, 17'h07f01);
        step(2'h1, 17'h10001);
        step(2'h3, 17'h0);
        $display("directed sequence done");
        for (i = 0; i < 60; i++) begin
            lf = lfsr(lf);
            step(lf[18:17], lf[16:0]);
        end
        $display("random sequence done");
        report_and_stop();
    end
    initial begin
        #5000;
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
